// >>> pkg/sfe_consts.svh
// Purpose: Shared constants for the serial flash wipe sequencer link
// Assumes: 125 MHz system clock on both ends
// Notes:   Opcode values are local choices, held here and repeated as literals in the bench bit-banged frames
//
// Summary of operation
// [R1] Sector wipe erases one aligned 4 KByte sector
// [R2] Host sets write permit before any wipe
// [R3] Finished erase clears the write permit latch
// [R4] Host holds select low for whole frame
// [R5] Sector wipe: command byte, three address bytes
// [R6] Erase starts when select rises after frame
// [R7] Busy device ignores all but status fetch
// [R8] Progress flag reads 1 while erase runs
// [R9] Progress flag reads 0 once erase ends
// [R10] Block wipe erases one 64/32 KByte block
// [R11] Block wipe runs only on exact frame
// [R12] Full wipe: command byte only, erases all
// [R13] Status write stays busy at most 10 ms
// [R14] Input bits sampled on rising serial clock
// [R15] No permit: no erase, flag stays 0
// [R16] Low address bits ignored, region aligned
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SFE_OP_PERMIT   8'h06
`define SFE_OP_UNPERMIT 8'h04
`define SFE_OP_STATUS   8'h05
`define SFE_OP_WRSTAT   8'h01
`define SFE_OP_SECTOR   8'h20
`define SFE_OP_BLOCK    8'hd8
`define SFE_OP_FULL     8'hc7

// ----------------------------------------------------------------
// Frame lengths in bits
// ----------------------------------------------------------------
`define SFE_BITS_CMD    6'h08
`define SFE_BITS_WRSTAT 6'h10
`define SFE_BITS_ADDR   6'h20

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define SFE_STAT_BUSY_BIT   0
`define SFE_STAT_PERMIT_BIT 1
`define SFE_STAT_RST    6'h00

// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define SFE_SECTOR_BYTES 4096
`define SFE_BLOCK_KB     64
`define SFE_ERASE_MS     10
`define SFE_WRSTAT_MS    10
`define SFE_CLK_KHZ      125000
`define SFE_MS_TO_CYC(ms) ((ms) * `SFE_CLK_KHZ)
`define SFE_HALF_CYC     10

`endif

// >>> pkg/sfe_pkg.sv
// Purpose: Types for the serial flash wipe sequencer ends
// Assumes: Constants come from sfe_consts.svh
// Notes:   Each end keeps its whole state in one packed struct
package sfe_pkg;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NONE   = 2'b00,
        KIND_SECTOR = 2'b01,
        KIND_BLOCK  = 2'b10,
        KIND_FULL   = 2'b11
    } sfe_kind_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW  = 3'b001,
        H_HIGH = 3'b010,
        H_END  = 3'b011,
        H_GAP  = 3'b100
    } sfe_hstate_t;

    // ----------------------------------------------------------------
    // Device state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  sclkS;
        logic [2:0]  csS;
        logic [1:0]  mosiS;
        logic [5:0]  bitCnt;
        logic [31:0] shift;
        logic [7:0]  op;
        logic [7:0]  misoSh;
        logic        miso;
        logic        permit;
        logic [5:0]  statHi;
        logic        busy;
        logic [31:0] busyCnt;
        logic        start;
        logic        done;
        sfe_kind_t   kind;
        logic [23:0] base;
    } sfe_dev_t;

    // ----------------------------------------------------------------
    // Host state
    // ----------------------------------------------------------------
    typedef struct packed {
        sfe_hstate_t st;
        logic [7:0]  div;
        logic [39:0] tx;
        logic [5:0]  bits;
        logic [7:0]  rx;
        logic [1:0]  misoS;
        logic        sclk;
        logic        csN;
        logic        mosi;
        logic        follow;
        logic [39:0] sv;
        logic [5:0]  svBits;
        logic        ready;
        logic        rspValid;
    } sfe_host_t;

endpackage : sfe_pkg

// >>> pkg/sfe_link_if.sv
// Purpose: Four-wire serial link between host and flash device
// Assumes: Host makes the serial clock and the select
// Notes:   Mode 0: data sampled on rising, changed on falling edge
interface sfe_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic miso;

    modport dev (
        input  sclk,
        input  csN,
        input  mosi,
        output miso
    );

    modport host (
        output sclk,
        output csN,
        output mosi,
        input  miso
    );
endinterface : sfe_link_if

// >>> hw/sfe_device.sv
// Purpose: Flash end: decodes wipe commands, runs timed erase
// Assumes: Serial link pins are asynchronous to clk
// Notes:   Link pins pass two flip-flops before any logic
`include "sfe_consts.svh"

module sfe_device #(
    parameter int BLOCK_KB   = `SFE_BLOCK_KB,
    parameter int ERASE_CYC  = `SFE_MS_TO_CYC(`SFE_ERASE_MS),
    parameter int WRSTAT_CYC = `SFE_MS_TO_CYC(`SFE_WRSTAT_MS)
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Serial link
    sfe_link_if.dev                 link,
    // Array side
    output      logic               wipeStart,
    output      sfe_pkg::sfe_kind_t wipeKind,
    output      logic [23:0]        wipeBase,
    output      logic               wipeDone,
    output      logic               busy,
    output      logic               permit
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (BLOCK_KB != 32 && BLOCK_KB != 64) begin : g_chk_blk
        $error("BLOCK_KB must be 32 or 64");
    end
    if (ERASE_CYC < 1 || WRSTAT_CYC < 1) begin : g_chk_cyc
        $error("Busy counts must be at least one cycle");
    end
    if ((BLOCK_KB * 1024) % `SFE_SECTOR_BYTES != 0) begin : g_chk_geo
        $error("A block must span whole sectors");
    end

    localparam logic [23:0] SECTOR_MASK = 24'(`SFE_SECTOR_BYTES - 1);
    localparam logic [23:0] BLOCK_MASK  = 24'(BLOCK_KB * 1024 - 1);
    localparam logic [31:0] ERASE_LEN   = 32'(ERASE_CYC);
    localparam logic [31:0] WRSTAT_LEN  = 32'(WRSTAT_CYC);

    sfe_pkg::sfe_dev_t q;
    sfe_pkg::sfe_dev_t n;

    logic       sclkRise;
    logic       sclkFall;
    logic       csRise;
    logic       selected;
    logic       inBit;
    logic [7:0] stat;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = q;
        n.start   = 1'b0;
        n.done    = 1'b0;

        // ----------------------------------------------------------------
        // Pin synchronisers and edge detection
        // ----------------------------------------------------------------
        n.sclkS   = {q.sclkS[1:0], link.sclk};
        n.csS     = {q.csS[1:0], link.csN};
        n.mosiS   = {q.mosiS[0], link.mosi};
        sclkRise  = q.sclkS[1] & ~q.sclkS[2];
        sclkFall  = ~q.sclkS[1] & q.sclkS[2];
        csRise    = q.csS[1] & ~q.csS[2];
        selected  = ~q.csS[1];
        inBit     = q.mosiS[1];

        // ----------------------------------------------------------------
        // Live status byte
        // ----------------------------------------------------------------
        stat                       = {q.statHi, 2'b00};
        stat[`SFE_STAT_BUSY_BIT]   = q.busy; // [R8] [R9]
        stat[`SFE_STAT_PERMIT_BIT] = q.permit;

        // ----------------------------------------------------------------
        // Bit capture while selected
        // ----------------------------------------------------------------
        if (selected) begin
            if (sclkRise) begin
                n.shift = {q.shift[30:0], inBit}; // [R14]
                if (q.bitCnt != 6'h3f) begin
                    n.bitCnt = q.bitCnt + 6'h01;
                end
                if (q.bitCnt == 6'h07) begin
                    n.op = {q.shift[6:0], inBit};
                end
            end
            // Status stays readable while busy; live value each byte
            if (sclkFall && q.op == `SFE_OP_STATUS && q.bitCnt >= `SFE_BITS_CMD) begin
                if (q.bitCnt[2:0] == 3'h0) begin
                    n.miso   = stat[7];
                    n.misoSh = {stat[6:0], 1'b0};
                end else begin
                    n.miso   = q.misoSh[7];
                    n.misoSh = {q.misoSh[6:0], 1'b0};
                end
            end
        end else begin
            n.bitCnt = 6'h00;
            n.op     = 8'h00;
            n.miso   = 1'b0;
        end

        // ----------------------------------------------------------------
        // Timed operation in progress
        // ----------------------------------------------------------------
        if (q.busy) begin
            if (q.busyCnt <= 32'h0000_0001) begin
                n.busy    = 1'b0; // [R9]
                n.permit  = 1'b0; // [R3]
                n.done    = 1'b1;
                n.busyCnt = 32'h0000_0000;
            end else begin
                n.busyCnt = q.busyCnt - 32'h0000_0001; // [R8]
            end
        end

        // ----------------------------------------------------------------
        // Decode at frame end; nothing is taken while busy
        // ----------------------------------------------------------------
        // Busy gate also drops a frame ending on the last busy cycle
        if (csRise && !q.busy) begin // [R7]
            case (q.op)
                `SFE_OP_PERMIT: begin
                    if (q.bitCnt == `SFE_BITS_CMD) begin
                        n.permit = 1'b1;
                    end
                end
                `SFE_OP_UNPERMIT: begin
                    if (q.bitCnt == `SFE_BITS_CMD) begin
                        n.permit = 1'b0;
                    end
                end
                `SFE_OP_WRSTAT: begin
                    if (q.bitCnt == `SFE_BITS_WRSTAT && q.permit) begin
                        n.statHi  = q.shift[7:2];
                        n.busy    = 1'b1;
                        n.busyCnt = WRSTAT_LEN; // [R13]
                    end
                end
                `SFE_OP_SECTOR: begin
                    if (q.bitCnt == `SFE_BITS_ADDR && q.permit) begin // [R6] [R15]
                        n.kind    = sfe_pkg::KIND_SECTOR;
                        n.base    = q.shift[23:0] & ~SECTOR_MASK; // [R1] [R16]
                        n.start   = 1'b1;
                        n.busy    = 1'b1;
                        n.busyCnt = ERASE_LEN;
                    end
                end
                `SFE_OP_BLOCK: begin
                    if (q.bitCnt == `SFE_BITS_ADDR && q.permit) begin // [R11] [R15]
                        n.kind    = sfe_pkg::KIND_BLOCK;
                        n.base    = q.shift[23:0] & ~BLOCK_MASK; // [R10] [R16]
                        n.start   = 1'b1;
                        n.busy    = 1'b1;
                        n.busyCnt = ERASE_LEN;
                    end
                end
                `SFE_OP_FULL: begin
                    if (q.bitCnt == `SFE_BITS_CMD && q.permit) begin // [R12] [R15]
                        n.kind    = sfe_pkg::KIND_FULL;
                        n.base    = 24'h00_0000;
                        n.start   = 1'b1;
                        n.busy    = 1'b1;
                        n.busyCnt = ERASE_LEN;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            // Permit latch clear from reset: no wipe without a fresh permit
            q.permit  <= 1'b0;
            q.busy    <= 1'b0;
            q.sclkS   <= 3'h0;
            q.csS     <= 3'h7;
            q.statHi  <= `SFE_STAT_RST;
            q.kind    <= sfe_pkg::KIND_NONE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.miso = q.miso;
    assign wipeStart = q.start;
    assign wipeKind  = q.kind;
    assign wipeBase  = q.base;
    assign wipeDone  = q.done;
    assign busy      = q.busy;
    assign permit    = q.permit;

endmodule // sfe_device

// >>> hw/sfe_host.sv
// Purpose: Host end: frames commands onto the serial link
// Assumes: Serial clock made here by dividing clk
// Notes:   Wipes and status writes get a permit frame first
`include "sfe_consts.svh"

module sfe_host #(
    parameter int HALF_CYC = `SFE_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Serial link
    sfe_link_if.host         link,
    // Request
    input  wire logic        reqValid,
    input  wire logic [7:0]  reqOp,
    input  wire logic [31:0] reqTail,
    input  wire logic [2:0]  reqBytes,
    output      logic        reqReady,
    // Answer
    output      logic        rspValid,
    output      logic [7:0]  rspByte
);

    // Device samples through two flip-flops, so halves need margin
    if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_chk_half
        $error("HALF_CYC must lie in 6..255");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    sfe_pkg::sfe_host_t q;
    sfe_pkg::sfe_host_t n;

    logic tick;
    logic needPermit;

    always_comb begin
        n          = q;
        n.rspValid = 1'b0;
        n.misoS    = {q.misoS[0], link.miso};
        tick       = (q.div == HALF_LAST);
        n.div      = tick ? 8'h00 : q.div + 8'h01;
        needPermit = (reqOp == `SFE_OP_SECTOR) || (reqOp == `SFE_OP_BLOCK) ||
                     (reqOp == `SFE_OP_FULL) || (reqOp == `SFE_OP_WRSTAT);

        unique case (q.st)
            sfe_pkg::H_IDLE: begin
                n.div = 8'h00;
                if (q.follow) begin
                    n.follow = 1'b0;
                    n.tx     = q.sv;
                    n.bits   = q.svBits;
                    n.csN    = 1'b0; // [R4]
                    n.mosi   = q.sv[39];
                    n.st     = sfe_pkg::H_LOW;
                end else if (reqValid && q.ready) begin
                    n.ready = 1'b0;
                    n.csN   = 1'b0; // [R4]
                    n.st    = sfe_pkg::H_LOW;
                    if (needPermit) begin
                        n.sv     = {reqOp, reqTail};
                        n.svBits = {reqBytes, 3'h0};
                        n.follow = 1'b1;
                        n.tx     = {`SFE_OP_PERMIT, 32'h0000_0000}; // [R2]
                        n.bits   = `SFE_BITS_CMD;
                        n.mosi   = 1'b0;
                    end else begin
                        n.tx   = {reqOp, reqTail};
                        n.bits = {reqBytes, 3'h0};
                        n.mosi = reqOp[7];
                    end
                end
            end
            sfe_pkg::H_LOW: begin
                if (tick) begin
                    n.sclk = 1'b1;
                    n.st   = sfe_pkg::H_HIGH;
                end
            end
            sfe_pkg::H_HIGH: begin
                if (tick) begin
                    n.rx   = {q.rx[6:0], q.misoS[1]};
                    n.sclk = 1'b0;
                    n.tx   = {q.tx[38:0], 1'b0}; // [R5] [R12]
                    n.bits = q.bits - 6'h01;
                    if (q.bits == 6'h01) begin
                        n.mosi = 1'b0;
                        n.st   = sfe_pkg::H_END;
                    end else begin
                        n.mosi = q.tx[38];
                        n.st   = sfe_pkg::H_LOW;
                    end
                end
            end
            sfe_pkg::H_END: begin
                if (tick) begin
                    n.csN = 1'b1;
                    n.st  = sfe_pkg::H_GAP;
                end
            end
            sfe_pkg::H_GAP: begin
                if (tick) begin
                    n.st       = sfe_pkg::H_IDLE;
                    n.ready    = ~q.follow;
                    n.rspValid = ~q.follow;
                end
            end
            default: begin
                n.st = sfe_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q       <= '0;
            q.st    <= sfe_pkg::H_IDLE;
            q.csN   <= 1'b1;
            q.ready <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign link.sclk = q.sclk;
    assign link.csN  = q.csN;
    assign link.mosi = q.mosi;
    assign reqReady  = q.ready;
    assign rspValid  = q.rspValid;
    assign rspByte   = q.rx;

endmodule // sfe_host

// >>> dv/sfe_link_checker.sv
// Purpose: Concurrent checks on the host-device serial link
// Assumes: Instantiated beside the link joining both design ends
// Notes:   BUSY_CYC matches the erase and status write busy length
module sfe_link_checker #(
    parameter int BUSY_CYC = 2000
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Serial link
    input wire logic               sclk,
    input wire logic               csN,
    input wire logic               mosi,
    // Device side
    input wire logic               wipeStart,
    input wire sfe_pkg::sfe_kind_t wipeKind,
    input wire logic [23:0]        wipeBase,
    input wire logic               wipeDone,
    input wire logic               busy,
    input wire logic               permit
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // Busy run length
    // ----------------------------------------------------------------
    logic [31:0] runCnt_q;
    logic [31:0] runCnt_d;
    always_comb runCnt_d = busy ? runCnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runCnt_q <= 32'h0;
        end else begin
            runCnt_q <= runCnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_run;
        busy [*8];
    endsequence
    sequence s_erase_end;
        !busy && !permit ##1 !busy;
    endsequence

    property p_clk_idle;
        csN |-> !sclk;
    endproperty
    property p_bit_stable;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    property p_start_permit;
        wipeStart |-> permit ##0 s_run;
    endproperty
    property p_start_frame;
        wipeStart |-> $past(csN, 2) && !$past(csN, 12);
    endproperty
    property p_no_restart;
        busy |=> !wipeStart;
    endproperty
    property p_done_clears;
        wipeDone |-> s_erase_end;
    endproperty
    property p_busy_len;
        wipeDone |-> runCnt_q inside {[BUSY_CYC - 1 : BUSY_CYC + 1]};
    endproperty
    property p_sector_base;
        wipeStart && wipeKind == sfe_pkg::KIND_SECTOR |-> wipeBase[11:0] == 12'h000;
    endproperty
    property p_block_base;
        wipeStart && wipeKind == sfe_pkg::KIND_BLOCK |-> wipeBase[15:0] == 16'h0000;
    endproperty
    property p_full_base;
        wipeStart && wipeKind == sfe_pkg::KIND_FULL |-> wipeBase == 24'h000000;
    endproperty

    a_clk_idle: assert property (p_clk_idle)
        else $error("serial clock high outside frame");
    a_bit_stable: assert property (p_bit_stable)
        else $error("data moved while serial clock high");
    a_start_permit: assert property (p_start_permit)
        else $error("erase start without permit or busy");
    a_start_frame: assert property (p_start_frame)
        else $error("erase start not tied to select rise");
    a_no_restart: assert property (p_no_restart)
        else $error("erase started while busy");
    a_done_clears: assert property (p_done_clears)
        else $error("finish left busy or permit set");
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    a_sector_base: assert property (p_sector_base)
        else $error("sector base not aligned");
    a_block_base: assert property (p_block_base)
        else $error("block base not aligned");
    a_full_base: assert property (p_full_base)
        else $error("full wipe base not zero");
endmodule // sfe_link_checker

// >>> dv/serial_flash_erase_sequencer_bench.sv
// Purpose: Self-checking bench for host and device across the link
// Assumes: Second device on its own link is driven bit by bit here
// Notes:   Short busy length keeps the run brief
`include "sfe_consts.svh"
`define SFE_CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end

module serial_flash_erase_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY = 2000;

    logic               clk;
    logic               rst_n;
    logic               reqValid;
    logic [7:0]         reqOp;
    logic [31:0]        reqTail;
    logic [2:0]         reqBytes;
    logic               reqReady;
    logic               rspValid;
    logic [7:0]         rspByte;
    logic               wipeStart;
    sfe_pkg::sfe_kind_t wipeKind;
    logic [23:0]        wipeBase;
    logic               wipeDone;
    logic               busy;
    logic               permit;
    logic               start2;
    sfe_pkg::sfe_kind_t kind2;
    logic               busy2;
    logic               permit2;
    logic [23:0]        base2;
    logic [25:0]        wexp;
    logic [25:0]        wipeQ[$];
    logic [8:0]         rspQ[$];
    logic [8:0]         note;
    logic [23:0]        addr;
    int                 n_errors = 0;
    int                 num_checks = 0;
    int                 nSt2 = 0;

    sfe_link_if lk ();
    sfe_link_if lk2 ();

    sfe_host #(.HALF_CYC(10)) sfe_host_i (.clk(clk), .rst_n(rst_n), .link(lk.host),
        .reqValid(reqValid), .reqOp(reqOp), .reqTail(reqTail), .reqBytes(reqBytes),
        .reqReady(reqReady), .rspValid(rspValid), .rspByte(rspByte));
    sfe_device #(.BLOCK_KB(64), .ERASE_CYC(BUSY), .WRSTAT_CYC(BUSY)) sfe_device_i (
        .clk(clk), .rst_n(rst_n), .link(lk.dev), .wipeStart(wipeStart),
        .wipeKind(wipeKind), .wipeBase(wipeBase), .wipeDone(wipeDone), .busy(busy),
        .permit(permit));
    // Faulty host stands in on the second link
    sfe_device #(.BLOCK_KB(32), .ERASE_CYC(BUSY), .WRSTAT_CYC(BUSY)) sfe_device_i2 (
        .clk(clk), .rst_n(rst_n), .link(lk2.dev), .wipeStart(start2), .wipeKind(kind2),
        .wipeBase(base2), .wipeDone(), .busy(busy2), .permit(permit2));
    sfe_link_checker #(.BUSY_CYC(BUSY)) sfe_link_checker_i (.clk(clk), .rst_n(rst_n),
        .sclk(lk.sclk), .csN(lk.csN), .mosi(lk.mosi), .wipeStart(wipeStart),
        .wipeKind(wipeKind), .wipeBase(wipeBase), .wipeDone(wipeDone), .busy(busy),
        .permit(permit));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (start2 === 1'b1) nSt2++;
        if (wipeStart === 1'b1) begin
            if (wipeQ.size() == 0) `SFE_CHK(wipeStart, 1'b0)
            else begin
                wexp = wipeQ.pop_front();
                `SFE_CHK({wipeKind, wipeBase}, wexp)
            end
        end
        if (rspValid === 1'b1 && rspQ.size() > 0) begin
            note = rspQ.pop_front();
            if (note[8]) `SFE_CHK(rspByte, note[7:0])
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic send(input logic [7:0] op, input logic [31:0] tail,
                        input logic [2:0] nb, input logic [8:0] exp);
        int k;
        k = 0;
        do @(posedge clk); while (reqReady !== 1'b1 && ++k < 3000);
        rspQ.push_back(exp);
        reqValid <= 1'b1;
        reqOp    <= op;
        reqTail  <= tail;
        reqBytes <= nb;
        @(posedge clk);
        reqValid <= 1'b0;
        k = 0;
        do @(posedge clk); while (rspValid !== 1'b1 && ++k < 3000);
        if (k >= 3000) n_errors++;
    endtask

    task automatic waitDone();
        int k;
        k = 0;
        do @(posedge clk); while (wipeDone !== 1'b1 && ++k < 5000);
        if (k >= 5000) n_errors++;
    endtask

    // Bit-banged frame, first bit at v[39]; 160 ns serial period
    task automatic bang(input logic [39:0] v, input int n);
        lk2.csN  <= 1'b0;
        lk2.mosi <= v[39];
        for (int i = 0; i < n; i++) begin
            repeat (10) @(posedge clk);
            lk2.sclk <= 1'b1;
            repeat (10) @(posedge clk);
            lk2.sclk <= 1'b0;
            lk2.mosi <= v[38-i];
        end
        repeat (10) @(posedge clk);
        lk2.csN  <= 1'b1;
        lk2.mosi <= ~lk2.mosi;
        repeat (20) @(posedge clk);
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqOp = 8'h00;
        reqTail = 32'h0;
        reqBytes = 3'h0;
        lk2.sclk = 1'b0;
        lk2.csN = 1'b1;
        lk2.mosi = 1'b0;
        void'($urandom(20));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        // Sector wipe; status and a block wipe while busy
        addr = 24'($urandom);
        wipeQ.push_back({sfe_pkg::KIND_SECTOR, addr & 24'hfff000});
        send(`SFE_OP_SECTOR, {addr, 8'h00}, 3'h4, 9'h000);
        send(`SFE_OP_STATUS, 32'h0, 3'h2, 9'h103);
        send(`SFE_OP_BLOCK, {addr, 8'h00}, 3'h4, 9'h000);
        waitDone();
        `SFE_CHK(permit, 1'b0)
        send(`SFE_OP_STATUS, 32'h0, 3'h2, 9'h100);
        addr = 24'($urandom);
        wipeQ.push_back({sfe_pkg::KIND_BLOCK, addr & 24'hff0000});
        send(`SFE_OP_BLOCK, {addr, 8'h00}, 3'h4, 9'h000);
        waitDone();
        wipeQ.push_back({sfe_pkg::KIND_FULL, 24'h000000});
        send(`SFE_OP_FULL, 32'h0, 3'h1, 9'h000);
        waitDone();
        send(`SFE_OP_WRSTAT, 32'hfc000000, 3'h2, 9'h000);
        repeat (8) @(posedge clk);
        `SFE_CHK(busy, 1'b1)
        waitDone();
        send(`SFE_OP_STATUS, 32'h0, 3'h2, 9'h1fc);
        // Faulty host on the second link
        bang({8'h20, addr, 8'h00}, 32);
        `SFE_CHK(busy2, 1'b0)
        bang({8'h06, 32'h0}, 8);
        `SFE_CHK(permit2, 1'b1)
        bang({8'hd8, addr, 8'h00}, 31);
        `SFE_CHK(nSt2, 0)
        bang({8'hd8, addr, 8'h00}, 32);
        `SFE_CHK(nSt2, 1)
        `SFE_CHK({kind2, base2}, {sfe_pkg::KIND_BLOCK, addr & 24'hff8000})
        bang({8'hc7, 32'h0}, 8);
        `SFE_CHK(nSt2, 1)
        repeat (BUSY) @(posedge clk);
        `SFE_CHK(permit2, 1'b0)
        bang({8'h06, 32'h0}, 8);
        bang({8'hc7, 32'h0}, 8);
        `SFE_CHK(nSt2, 2)
        `SFE_CHK(kind2, sfe_pkg::KIND_FULL)
        `SFE_CHK(wipeQ.size(), 0)
        conclude();
    end
endmodule // serial_flash_erase_sequencer_bench
